// ### sram_host_ctrl.sv
// Controller that drives an asynchronous 256K x 16 static RAM
`timescale 1ns/1ns
`default_nettype none
`include "sram_timing_defs.svh"
// Functional notes
// - chip enable held before write ends
// - byte enable held before write ends
// - write control high throughout reads
// - never drive against possibly driving memory
// - deselect for retention, wait recovery after
module sram_host_ctrl #(
   parameter int ADDR_W       = 18,
   parameter int DATA_W       = 16,
   parameter int RECOVERY_CYC = `CYC_RECOVERY_DEF
) (
   input  wire logic              clk,
   input  wire logic              nrst,
   input  wire logic              reqValid,
   input  wire logic              reqWrite,
   input  wire logic [ADDR_W-1:0] reqAddr,
   input  wire logic [DATA_W-1:0] reqWdata,
   input  wire logic [1:0]        reqLanes,
   input  wire logic              sleepReq,
   input  wire logic              wakeReq,
   output logic                   reqReady,
   output logic                   rdValid,
   output logic [DATA_W-1:0]      rdData,
   output logic                   asleep,
   output logic [ADDR_W-1:0]      word_address,
   output logic                   chipEnable_n,
   output logic                   chipSelect,
   output logic                   outEnable_n,
   output logic                   writeRead,
   output logic                   low_byte_enable_n,
   output logic                   high_byte_enable_n,
   input  wire logic [DATA_W-1:0] data_pins_in,
   output logic [DATA_W-1:0]      data_pins_out,
   output logic [DATA_W-1:0]      data_pins_oe
);
   // Refuse widths and counts that the pin map and the timer cannot serve
   if (ADDR_W != 18 || DATA_W != 16
       || RECOVERY_CYC < 1 || RECOVERY_CYC > 16777215) begin : g_badParams
      $error("sram_host_ctrl: unsupported parameter value");
   end

   ////////////////////////////////////////////////////////////////////////////
   // Reset release
   logic rstMeta_q;
   logic rstSync;
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rstMeta_q <= 1'b0;
         rstSync   <= 1'b0;
      end else begin
         rstMeta_q <= 1'b1;
         rstSync   <= rstMeta_q;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Cycle timer
   sram_wait_if waitBus ();
   sram_wait_timer u_timer (
      .clk     (clk),
      .rstSync (rstSync),
      .tmr     (waitBus)
   );

   // Expand a two-bit lane mask into per-pin enables
   function automatic logic [DATA_W-1:0] laneMask(input logic [1:0] lanes);
      laneMask = {{8{lanes[1]}}, {8{lanes[0]}}};
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Sequencer state
   sram_ctrl_pkg::phase_type st_q, st_d;
   logic              ready_q, ready_d, rdv_q, rdv_d, sleep_q, sleep_d;
   logic [DATA_W-1:0] rdat_q, rdat_d, wdat_q, wdat_d, oe_q, oe_d;
   logic [ADDR_W-1:0] addr_q, addr_d;
   logic              ce_q, ce_d, cs_q, cs_d, oen_q, oen_d, wr_q, wr_d;
   logic [1:0]        lanes_q, lanes_d;
   logic              load;
   logic [23:0]       count;

   // Next-state and pin decisions for every phase
   always_comb begin
      st_d = st_q;  ready_d = 1'b0;  rdv_d = 1'b0;  sleep_d = sleep_q;
      rdat_d = rdat_q;  wdat_d = wdat_q;  oe_d = oe_q;  addr_d = addr_q;
      ce_d = ce_q;  cs_d = cs_q;  oen_d = oen_q;  wr_d = wr_q;  lanes_d = lanes_q;
      load = 1'b0;  count = 24'h000000;
      unique case (st_q)
         sram_ctrl_pkg::ST_IDLE: begin
            ce_d = 1'b1;  oen_d = 1'b1;  wr_d = 1'b1;  lanes_d = 2'h3;  oe_d = '0;
            ready_d = waitBus.done && !sleepReq;
            if (sleepReq && waitBus.done) begin
               cs_d = 1'b0;
               sleep_d = 1'b1;
               st_d = sram_ctrl_pkg::ST_SLEEP;
            end else if (ready_q && reqValid) begin
               ready_d = 1'b0;  // One request at a time
               addr_d = reqAddr;  ce_d = 1'b0;  cs_d = 1'b1;
               lanes_d = ~reqLanes;
               load = 1'b1;
               if (reqWrite) begin
                  wr_d = 1'b0;  // Write control low with enables: outputs stay floating
                  wdat_d = reqWdata;
                  count = 24'(`CYC_WPULSE - 1);
                  st_d = sram_ctrl_pkg::ST_WRITE;
               end else begin
                  oen_d = 1'b0;  // Bus already released
                  count = 24'(`CYC_ACCESS - 1);
                  st_d = sram_ctrl_pkg::ST_READ;
               end
            end
         end
         sram_ctrl_pkg::ST_READ: begin
            if (waitBus.done) begin
               rdat_d = data_pins_in & laneMask(~lanes_q);
               rdv_d = 1'b1;
               ce_d = 1'b1;  oen_d = 1'b1;  lanes_d = 2'h3;
               load = 1'b1;
               count = 24'(`CYC_HIGHZ - 1);
               st_d = sram_ctrl_pkg::ST_RFLOAT;
            end
         end
         sram_ctrl_pkg::ST_RFLOAT: begin
            if (waitBus.done) begin  // Float wait over: bus free again
               st_d = sram_ctrl_pkg::ST_IDLE;
            end
         end
         sram_ctrl_pkg::ST_WRITE: begin
            oe_d = laneMask(~lanes_q);  // Drive only enabled lanes, memory floated
            if (waitBus.done) begin
               wr_d = 1'b1;  // End write before releasing enables
               load = 1'b1;
               count = 24'h000001;
               st_d = sram_ctrl_pkg::ST_WEND;
            end
         end
         sram_ctrl_pkg::ST_WEND: begin
            ce_d = 1'b1;  lanes_d = 2'h3;  oe_d = '0;  // Zero hold
            if (waitBus.done) begin
               st_d = sram_ctrl_pkg::ST_IDLE;
            end
         end
         sram_ctrl_pkg::ST_SLEEP: begin
            if (wakeReq) begin
               load = 1'b1;
               count = 24'(RECOVERY_CYC);
               st_d = sram_ctrl_pkg::ST_RECOVER;
            end
         end
         sram_ctrl_pkg::ST_RECOVER: begin
            if (waitBus.done) begin
               sleep_d = 1'b0;
               st_d = sram_ctrl_pkg::ST_IDLE;
            end
         end
      endcase
   end

   assign waitBus.load  = load;
   assign waitBus.count = count;

   // Register every state bit and pin
   always_ff @(posedge clk or negedge rstSync) begin
      if (!rstSync) begin
         st_q <= sram_ctrl_pkg::ST_IDLE;
         ready_q <= 1'b0;  rdv_q <= 1'b0;  sleep_q <= 1'b0;
         rdat_q <= '0;  wdat_q <= '0;  oe_q <= '0;  addr_q <= '0;
         ce_q <= 1'b1;  cs_q <= 1'b0;  oen_q <= 1'b1;  wr_q <= 1'b1;  lanes_q <= 2'h3;
      end else begin
         st_q <= st_d;
         ready_q <= ready_d;  rdv_q <= rdv_d;  sleep_q <= sleep_d;
         rdat_q <= rdat_d;  wdat_q <= wdat_d;  oe_q <= oe_d;  addr_q <= addr_d;
         ce_q <= ce_d;  cs_q <= cs_d;  oen_q <= oen_d;  wr_q <= wr_d;  lanes_q <= lanes_d;
      end
   end

   assign reqReady           = ready_q;
   assign rdValid            = rdv_q;
   assign rdData             = rdat_q;
   assign asleep             = sleep_q;
   assign word_address       = addr_q;
   assign chipEnable_n       = ce_q;
   assign chipSelect         = cs_q;
   assign outEnable_n        = oen_q;
   assign writeRead          = wr_q;
   assign low_byte_enable_n  = lanes_q[0];
   assign high_byte_enable_n = lanes_q[1];
   assign data_pins_out      = wdat_q;
   assign data_pins_oe       = oe_q;

   ////////////////////////////////////////////////////////////////////////////
   // Assertions
   sequence s_readStart;
      $fell(outEnable_n) && writeRead;
   endsequence
   property p_noDriveOnOe;
      @(posedge clk) disable iff (!rstSync) !outEnable_n |-> data_pins_oe == '0;
   endproperty
   a_noDriveOnOe: assert property (p_noDriveOnOe) else $error("bus driven in read");
   property p_readHigh;
      @(posedge clk) disable iff (!rstSync) !outEnable_n |-> writeRead;
   endproperty
   a_readHigh: assert property (p_readHigh) else $error("write low in read");
   property p_access;
      @(posedge clk) disable iff (!rstSync) s_readStart |-> !outEnable_n[*4] ##1 outEnable_n;
   endproperty
   a_access: assert property (p_access) else $error("read access length wrong");
   property p_float;
      @(posedge clk) disable iff (!rstSync)
         $rose(outEnable_n) |-> (data_pins_oe == '0)[*2];
   endproperty
   a_float: assert property (p_float) else $error("drove during float");
   property p_wpulse;
      @(posedge clk) disable iff (!rstSync) $fell(writeRead) |-> (!writeRead && !chipEnable_n)[*3] ##1 writeRead;
   endproperty
   a_wpulse: assert property (p_wpulse) else $error("write pulse length wrong");
   property p_ceBeforeWe;
      @(posedge clk) disable iff (!rstSync) $rose(writeRead) |-> !chipEnable_n;
   endproperty
   a_ceBeforeWe: assert property (p_ceBeforeWe) else $error("enable left before write end");
   property p_laneDrive;
      @(posedge clk) disable iff (!rstSync) data_pins_oe[0] |-> !low_byte_enable_n;
   endproperty
   a_laneDrive: assert property (p_laneDrive) else $error("drove disabled lane");
   property p_select;
      @(posedge clk) disable iff (!rstSync) !chipEnable_n |-> chipSelect && !asleep;
   endproperty
   a_select: assert property (p_select) else $error("enable while deselected");
endmodule
`default_nettype wire

// ### sram_timing_defs.svh
// Timing figures and pin layout constants for the static RAM controller
`ifndef SRAM_TIMING_DEFS_SVH
`define SRAM_TIMING_DEFS_SVH
`define CLK_PERIOD_NS     20
`define T_CYCLE_NS        55
`define T_ACCESS_NS       55
`define T_OE_ACCESS_NS    30
`define T_HIGHZ_NS        25
`define T_WRITE_PULSE_NS  40
`define T_CE_TO_END_NS    45
`define T_DATA_SETUP_NS   25
`define T_RECOVERY_MS     5
// Nanosecond times round up to whole cycles, never below one cycle, with one cycle more for access; the recovery count rounds down
`define CYC_UP(ns)  ((((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS) < 1 ? 1 : \
                     (((ns) + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS))
`define CYC_ACCESS  (`CYC_UP(`T_ACCESS_NS) + 1)
`define CYC_CYCLE   `CYC_UP(`T_CYCLE_NS)
`define CYC_WPULSE  `CYC_UP(`T_CE_TO_END_NS)
`define CYC_HIGHZ   `CYC_UP(`T_HIGHZ_NS)
`define CYC_RECOVERY_DEF ((`T_RECOVERY_MS * 1000000) / `CLK_PERIOD_NS)
`define LOW_LANE_MSB  7
`define HIGH_LANE_LSB 8
`endif

// ### sram_ctrl_pkg.sv
// Types shared by the static RAM controller modules
package sram_ctrl_pkg;
   typedef enum logic [6:0] {
      ST_IDLE    = 7'b0000001,
      ST_READ    = 7'b0000010,
      ST_RFLOAT  = 7'b0000100,
      ST_WRITE   = 7'b0001000,
      ST_WEND    = 7'b0010000,
      ST_SLEEP   = 7'b0100000,
      ST_RECOVER = 7'b1000000
   } phase_type;
endpackage

// ### sram_wait_if.sv
// Interface between the sequencer and its cycle timer
`timescale 1ns/1ns
`default_nettype none
interface sram_wait_if;
   logic        load;
   logic [23:0] count;
   logic        done;
   modport seq (output load, output count, input done);
   modport tmr (input load, input count, output done);
endinterface
`default_nettype wire

// ### sram_wait_timer.sv
// Down counter that times each phase of a memory cycle
`timescale 1ns/1ns
`default_nettype none
module sram_wait_timer (
   input  wire logic    clk,
   input  wire logic    rstSync,
   sram_wait_if.tmr     tmr
);
   logic [23:0] cnt_q;
   logic [23:0] cnt_d;

   // Load a count, then run down to zero
   always_comb begin
      cnt_d = cnt_q;
      if (tmr.load) begin
         cnt_d = tmr.count;
      end else if (cnt_q != 24'h000000) begin
         cnt_d = cnt_q - 24'h000001;
      end
   end

   always_ff @(posedge clk or negedge rstSync) begin
      if (!rstSync) begin
         cnt_q <= 24'h000000;
      end else begin
         cnt_q <= cnt_d;
      end
   end

   // Done depends on the count alone, so the sequencer's load decision never loops back
   assign tmr.done = (cnt_q == 24'h000000);
endmodule
`default_nettype wire

// ### sram_device_model.sv
// Behavioural static RAM that answers the controller pins
`timescale 1ns/1ns
`default_nettype none
module sram_device_model (
   input  wire logic        clk,
   input  wire logic        slow,
   input  wire logic [17:0] word_address,
   input  wire logic        chipEnable_n,
   input  wire logic        chipSelect,
   input  wire logic        outEnable_n,
   input  wire logic        writeRead,
   input  wire logic        low_byte_enable_n,
   input  wire logic        high_byte_enable_n,
   input  wire logic [15:0] data_pins_out,
   input  wire logic [15:0] data_pins_oe,
   output logic [15:0]      data_pins_in,
   output int               faults
);
   logic [15:0] mem [logic [17:0]];
   logic [15:0] rdWord = 16'h0000;
   logic [15:0] drvOn = 16'h0000;
   logic [15:0] floatPat = 16'h0000;
   logic [15:0] laneOn;
   logic [15:0] drvEff;
   time         selFall = 0;
   initial faults = 0;
   function automatic logic [15:0] peek(input logic [17:0] a);
      return mem.exists(a) ? mem[a] : ~a[15:0];
   endfunction
   ////////////////////////////////////////////////////////////////////////
   // Lanes drive only in a plain selected read
   assign laneOn = {{8{!high_byte_enable_n}}, {8{!low_byte_enable_n}}}
      & {16{!chipEnable_n && chipSelect && !outEnable_n && writeRead}};
   // Turn-on is late, turn-off at once
   always @(laneOn) drvOn <= #(slow ? 40 : 6) laneOn;
   assign drvEff = drvOn & laneOn;
   // Old word lingers after an address change
   always @(word_address) rdWord <= #10 peek(word_address);
   // Released pins wander instead of holding a value
   always @(posedge clk) floatPat <= {floatPat[14:0], ~floatPat[15]};
   assign data_pins_in = (drvEff & rdWord) | (~drvEff & data_pins_oe & data_pins_out)
                         | (~drvEff & ~data_pins_oe & floatPat);
   ////////////////////////////////////////////////////////////////////////
   // Write capture at the end of the pulse
   always @(negedge chipEnable_n) selFall = $time;
   task automatic store();
      logic [15:0] w;
      w = peek(word_address);
      if (!low_byte_enable_n) w[7:0] = data_pins_out[7:0];
      if (!high_byte_enable_n) w[15:8] = data_pins_out[15:8];
      mem[word_address] = w;
      rdWord = w;
      if ($time - selFall < 45) faults++;
   endtask
   always @(posedge writeRead) if (!chipEnable_n && chipSelect) store();
   always @(posedge chipEnable_n) if (!writeRead && chipSelect) store();
   // Both sides driving one pin is a fault
   always @(negedge clk) if (|(drvEff & data_pins_oe)) faults++;
endmodule
`default_nettype wire

// ### sram_host_ctrl_bench.sv
// Self-checking bench for the static RAM controller
`timescale 1ns/1ns
`default_nettype none
module sram_host_ctrl_bench;
   logic        clk = 1'b0;
   logic        nrst = 1'b0;
   logic        reqValid = 1'b0;
   logic        reqWrite = 1'b0;
   logic [17:0] reqAddr = 18'h00000;
   logic [15:0] reqWdata = 16'h0000;
   logic [1:0]  reqLanes = 2'h0;
   logic        sleepReq = 1'b0;
   logic        wakeReq = 1'b0;
   logic        slow = 1'b0;
   logic        reqReady, rdValid, asleep, chipEnable_n, chipSelect, outEnable_n, writeRead;
   logic        low_byte_enable_n, high_byte_enable_n;
   logic [17:0] word_address;
   logic [15:0] rdData, data_pins_in, data_pins_out, data_pins_oe;
   logic [15:0] shadow [logic [17:0]];
   logic [17:0] pool [8];
   logic [31:0] rnd;
   int          faults, n_mismatch = 0, n_compared = 0, cyc = 0, i, k;
   sram_host_ctrl #(.RECOVERY_CYC(20)) sram_host_ctrl_inst (.clk(clk), .nrst(nrst),
      .reqValid(reqValid), .reqWrite(reqWrite), .reqAddr(reqAddr), .reqWdata(reqWdata),
      .reqLanes(reqLanes), .sleepReq(sleepReq), .wakeReq(wakeReq), .reqReady(reqReady),
      .rdValid(rdValid), .rdData(rdData), .asleep(asleep), .word_address(word_address),
      .chipEnable_n(chipEnable_n), .chipSelect(chipSelect), .outEnable_n(outEnable_n),
      .writeRead(writeRead), .low_byte_enable_n(low_byte_enable_n),
      .high_byte_enable_n(high_byte_enable_n), .data_pins_in(data_pins_in),
      .data_pins_out(data_pins_out), .data_pins_oe(data_pins_oe));
   sram_device_model sram_device_model_inst (.clk(clk), .slow(slow),
      .word_address(word_address), .chipEnable_n(chipEnable_n), .chipSelect(chipSelect),
      .outEnable_n(outEnable_n), .writeRead(writeRead), .low_byte_enable_n(low_byte_enable_n),
      .high_byte_enable_n(high_byte_enable_n), .data_pins_out(data_pins_out),
      .data_pins_oe(data_pins_oe), .data_pins_in(data_pins_in), .faults(faults));
   ////////////////////////////////////////////////////////////////////////
   // Clock and hang guard
   initial forever #10 clk = ~clk;
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_mismatch++;
         final_report();
      end
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      s = s ^ (s << 13);
      s = s ^ (s >> 17);
      return s ^ (s << 5);
   endfunction
   // Expected read word: unselected lanes read zero
   function automatic logic [15:0] expRead(input logic [17:0] a, input logic [1:0] ln);
      return {{8{ln[1]}}, {8{ln[0]}}} & (shadow.exists(a) ? shadow[a] : 16'h0000);
   endfunction
   task automatic check(input string what, input logic [17:0] exp, input logic [17:0] got);
      n_compared++;
      if (got !== exp) begin
         n_mismatch++;
         $display("MISMATCH %s expected %h seen %h", what, exp, got);
      end
   endtask
   // Select a watched flag: 0 ready, 1 read valid, 2 asleep
   function automatic logic pick(input int which);
      return which == 0 ? reqReady : (which == 1 ? rdValid : asleep);
   endfunction
   task automatic waitLvl(input int which, input logic v, output int n);
      n = 0;
      while (pick(which) !== v && n < 300) begin
         @(negedge clk);
         n++;
      end
   endtask
   // One request, taken at the edge after ready is seen
   task automatic doOp(input logic wr, input logic [17:0] a, input logic [15:0] d,
                       input logic [1:0] ln);
      int n;
      @(negedge clk);
      waitLvl(0, 1'b1, n);
      check("reqReady", 18'h00001, {17'h0, reqReady});
      reqValid = 1'b1;
      reqWrite = wr;
      reqAddr = a;
      reqWdata = d;
      reqLanes = ln;
      @(negedge clk);
      reqValid = 1'b0;
      if (wr) begin
         shadow[a] = expRead(a, ~ln) | ({{8{ln[1]}}, {8{ln[0]}}} & d);
      end else begin
         waitLvl(1, 1'b1, n);
         check("rdData", {2'b00, expRead(a, ln)}, {2'b00, rdData});
      end
   endtask
   task automatic final_report();
      $display("compared %0d mismatches %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Main sequence
   initial begin
      rnd = 32'd98;
      repeat (8) @(negedge clk);
      check("ce in reset", 18'h00001, {17'h0, chipEnable_n});
      check("bus in reset", 18'h00000, {2'b00, data_pins_oe});
      nrst = 1'b1;
      doOp(1'b1, 18'h3FFFF, 16'h1234, 2'h3);
      doOp(1'b1, 18'h3FFFF, 16'hABCD, 2'h1);
      for (i = 1; i < 4; i++) doOp(1'b0, 18'h3FFFF, 16'h0000, i[1:0]);
      for (i = 0; i < 8; i++) begin
         rnd = xs(rnd);
         pool[i] = rnd[17:0];
         doOp(1'b1, pool[i], rnd[31:16], 2'h3);
      end
      for (i = 0; i < 40; i++) begin
         rnd = xs(rnd);
         slow = rnd[5];
         doOp(rnd[4], pool[rnd[2:0]], rnd[31:16], rnd[7:6] == 2'h0 ? 2'h3 : rnd[7:6]);
      end
      sleepReq = 1'b1;
      waitLvl(2, 1'b1, k);
      sleepReq = 1'b0;
      check("sleep select", 18'h00000, {17'h0, chipSelect});
      check("sleep bus", 18'h00000, {2'b00, data_pins_oe});
      repeat (30) @(negedge clk);
      wakeReq = 1'b1;
      waitLvl(2, 1'b0, k);
      wakeReq = 1'b0;
      check("recovery", 18'h00001, {17'h0, k >= 20 && k < 300});
      for (i = 0; i < 8; i++) doOp(1'b0, pool[i], 16'h0000, 2'h3);
      check("faults", 18'h00000, 18'(faults));
      final_report();
   end
endmodule
`default_nettype wire
